// ---- rtl/tsc_pkg.sv ----
// tsc_pkg: constants and helpers of the tuner serial control logic
// assumes: compiled before rtl/tsc_top.sv, which imports all of it
package tsc_pkg;

  // bus address: five fixed upper bits, two strap bits, r/w bit last
  localparam logic [4:0] TSC_ADDR_HI = 5'h18;

  // bit counter: 0..7 data bits, 8 is the acknowledge slot
  localparam logic [3:0] TSC_BIT_LAST = 4'h7;
  localparam logic [3:0] TSC_BIT_ACK = 4'h8;

  // writable byte numbers and the size of the byte store
  localparam logic [3:0] TSC_FIRST_BYTE = 4'h2;
  localparam logic [3:0] TSC_LAST_BYTE = 4'hC;
  localparam int TSC_NREG = 11;

  // store index of a byte is its byte number minus two
  localparam int TSC_I_DIVH = 0;
  localparam int TSC_I_DIVL = 1;
  localparam int TSC_I_REF = 3;
  localparam int TSC_I_CTL = 4;
  localparam int TSC_I_BW = 5;
  localparam int TSC_I_FREF = 7;

  // field positions inside the bytes
  localparam int TSC_F_DIVH_MSB = 6;
  localparam int TSC_F_PORT = 7;
  localparam int TSC_F_REF_LSB = 0;
  localparam int TSC_F_BYP_OFF = 3;
  localparam int TSC_F_PD = 0;
  localparam int TSC_F_BW_LSB = 1;
  localparam int TSC_F_FREF_LSB = 2;

  // status byte layout
  localparam int TSC_S_POR = 7;
  localparam int TSC_S_LOCK = 6;

  // highest reference ratio code, 29 ratios
  localparam logic [4:0] TSC_REF_MAX = 5'h1C;

  // oscillator band limits on the main divider, plain defaults
  localparam logic [14:0] TSC_BAND_LO = 15'h0800;
  localparam logic [14:0] TSC_BAND_HI = 15'h1000;

  // reset contents of bytes 2..12
  localparam logic [7:0] TSC_RST [TSC_NREG] = '{
    8'h00, 8'h00, 8'h80, 8'h00, 8'hC0, 8'h20,
    8'hDB, 8'h30, 8'hE1, 8'h75, 8'hF0
  };

  // serial engine modes
  typedef enum logic [1:0] {M_ADDR, M_WRITE, M_READ, M_IGNORE} tsc_mode_t;

  // first byte of a write picks the starting even byte number
  function automatic logic [3:0] tsc_first_byte(input logic [7:0] b);
    logic [3:0] n;
    n = 4'h2;
    if (b[7] && !b[6]) n = 4'h4;
    if (b[7] && b[6]) n = 4'h6 + {1'b0, b[5:4], 1'b0};
    return n;
  endfunction

  // strap comparators (thermometer) to two id bits
  function automatic logic [1:0] tsc_strap(input logic [2:0] t);
    logic [1:0] id;
    case (t)
      3'h0: id = 2'h0;
      3'h1: id = 2'h1;
      3'h3: id = 2'h2;
      3'h7: id = 2'h3;
      default: id = 2'h1;
    endcase
    return id;
  endfunction

endpackage

// ---- rtl/tsc_top.sv ----
// tsc_top: serial slave and digital controls of a satellite tuner
// assumes: scl_i clocks the bit engine; sda is an open-drain wire
// resolved outside; pll_lock_i, sleep_i, strap_lvl_i are async pins
//
// Notes on behaviour
// - address r/w bit zero selects write mode, one selects read mode
// - strap level gnd/open/half/full gives id bits 00/01/10/11
// - answer write addresses C0..C6 and read addresses one higher
// - pull data low in ack slot after matching address and written bytes
// - master nack ends transmission until addressed again
// - analogue power down when sleep pin or power-down bit is one
// - bypass buffer follows its own bit only, off means powered down
// - bypass buffer enabled after power-up
// - lock pin shows the same lock state as status bit
// - general output released while bit zero, pulled low while one
// - both general output bits cleared at power-up
// - fifteen-bit main divider loaded from divider bytes
// - reference divider selects one of 29 ratios
// - oscillator band chosen automatically from the divider value
// - a read returns the eight-bit status byte again after each master ack
// - status bit 6 is one when locked
// - bytes after the twelfth register are ignored
`timescale 1ns/100ps

module tsc_top
  import tsc_pkg::*;
#(
  parameter logic [14:0] BAND_LIM_LO = TSC_BAND_LO,
  parameter logic [14:0] BAND_LIM_HI = TSC_BAND_HI
) (
  // system clock, reset, enable
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // serial bus pins
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n_o,
  // straps and analogue status pins
  input wire logic [2:0] strap_lvl_i,
  input wire logic sleep_i,
  input wire logic pll_lock_i,
  // pin controls
  output logic lock_o,
  output logic analog_pd_o,
  output logic bypass_en_o,
  output logic [1:0] port_out_o,
  output logic [1:0] port_out_oe_n_o,
  // synthesizer and filter codes
  output logic [14:0] pll_div_o,
  output logic [4:0] ref_div_sel_o,
  output logic [1:0] osc_band_o,
  output logic [5:0] filter_bw_code_o,
  output logic [4:0] filter_ref_div_o
);

  // clk domain synchronisers; *_m feeds *_s only
  logic scl_m, scl_s, scl_p, sda_m, sda_s, sda_p;
  logic slp_m, slp_s, lck_m, lck_s;
  logic rd_m, rd_s, wt_m, wt_s, wt_p;
  logic [2:0] stp_m, stp_s;
  logic start_ev, stop_ev, wr_ev;

  // serial side state, shared with the clk side through crossings
  tsc_mode_t mode, next_mode;
  logic [3:0] cnt, next_cnt;
  logic [7:0] sh, next_sh, tx, next_tx, rx_byte;
  logic ack_pend, next_ack, first, next_first, rd_act, next_rd;
  logic [3:0] wr_idx, next_widx;
  logic [7:0] wr_byte, next_wbyte;
  logic wr_tgl, next_wtgl, next_oe_n;
  logic [3:0] st_m, st_s;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      {scl_m, scl_s, scl_p} <= 3'h7;
      {sda_m, sda_s, sda_p} <= 3'h7;
      {slp_m, slp_s, lck_m, lck_s} <= 4'h0;
      {rd_m, rd_s, wt_m, wt_s, wt_p} <= 5'h00;
      stp_m <= 3'h0;
      stp_s <= 3'h0;
    end else if (ce_i) begin
      scl_m <= scl_i;
      scl_s <= scl_m;
      scl_p <= scl_s;
      sda_m <= sda_i;
      sda_s <= sda_m;
      sda_p <= sda_s;
      slp_m <= sleep_i;
      slp_s <= slp_m;
      lck_m <= pll_lock_i;
      lck_s <= lck_m;
      rd_m <= rd_act;
      rd_s <= rd_m;
      wt_m <= wr_tgl;
      wt_s <= wt_m;
      wt_p <= wt_s;
      stp_m <= strap_lvl_i;
      stp_s <= stp_m;
    end
  end

  // bus conditions seen on the synchronised pins
  assign start_ev = scl_s & scl_p & sda_p & ~sda_s;
  assign stop_ev = scl_s & scl_p & ~sda_p & sda_s;
  assign wr_ev = wt_s ^ wt_p;

  // frame control: bus_rst holds the serial engine idle between frames
  logic bus_rst, next_bus_rst, rst_pend, next_pend;
  logic por, next_por, strap_done, next_done;
  logic [1:0] strap_age, next_age;
  logic [1:0] id_bits, next_id;

  always_comb begin
    next_bus_rst = bus_rst;
    next_pend = 1'b0;
    next_por = por;
    next_id = id_bits;
    next_done = strap_done;
    next_age = strap_age;
    if (stop_ev) begin
      next_bus_rst = 1'b1;
    end else if (start_ev) begin
      // pulse even on a repeated start so the engine restarts
      next_bus_rst = 1'b1;
      next_pend = 1'b1;
    end else if (rst_pend) begin
      next_bus_rst = 1'b0;
    end
    // only a stop that ends a read clears the power-on flag
    if (stop_ev && rd_s) begin
      next_por = 1'b0;
    end
    // strap caught once, after two stages: earlier it shows the reset value
    if (!strap_done) begin
      next_age = strap_age + 2'h1;
      if (strap_age == 2'h2) begin
        next_id = tsc_strap(stp_s);
        next_done = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      bus_rst <= 1'b1;
      rst_pend <= 1'b0;
      por <= 1'b1;
      id_bits <= 2'h0;
      strap_done <= 1'b0;
      strap_age <= 2'h0;
    end else if (ce_i) begin
      bus_rst <= next_bus_rst;
      rst_pend <= next_pend;
      por <= next_por;
      id_bits <= next_id;
      strap_done <= next_done;
      strap_age <= next_age;
    end
  end

  // byte store, written from the serial side via toggle handshake
  logic [7:0] rf [TSC_NREG];
  logic [7:0] next_rf [TSC_NREG];

  always_comb begin
    next_rf = rf;
    // wr_idx and wr_byte are stable for a whole byte after the toggle
    if (wr_ev) begin
      next_rf[wr_idx - TSC_FIRST_BYTE] = wr_byte;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < TSC_NREG; i++) begin
        rf[i] <= TSC_RST[i];
      end
    end else if (ce_i) begin
      rf <= next_rf;
    end
  end

  // fields picked from the store
  logic pd_bit, byp_off;
  logic [1:0] port_bits;
  logic [14:0] div_val;
  logic [4:0] ref_code;
  assign pd_bit = rf[TSC_I_CTL][TSC_F_PD];
  assign byp_off = rf[TSC_I_CTL][TSC_F_BYP_OFF];
  assign port_bits = {rf[TSC_I_BW][TSC_F_PORT], rf[TSC_I_REF][TSC_F_PORT]};
  assign div_val = {rf[TSC_I_DIVH][TSC_F_DIVH_MSB:0], rf[TSC_I_DIVL]};
  assign ref_code = rf[TSC_I_REF][TSC_F_REF_LSB +: 5];

  // registered pin and code outputs
  logic [7:0] stat, next_stat;
  logic next_lock, next_pd, next_byp;
  logic [1:0] next_port, next_band;
  logic [14:0] next_div;
  logic [4:0] next_ref, next_fref;
  logic [5:0] next_bw;

  always_comb begin
    next_lock = lck_s;
    next_stat = {por, lck_s, 6'h00};
    next_pd = slp_s | pd_bit;
    next_byp = ~byp_off;
    next_port = ~port_bits;
    next_div = div_val;
    // codes past the last ratio clamp to it
    next_ref = (ref_code > TSC_REF_MAX) ? TSC_REF_MAX : ref_code;
    // band follows the divider, no software control
    if (div_val < BAND_LIM_LO) begin
      next_band = 2'h0;
    end else if (div_val < BAND_LIM_HI) begin
      next_band = 2'h1;
    end else begin
      next_band = 2'h2;
    end
    // ranges are software's duty, codes pass unchanged
    next_bw = rf[TSC_I_BW][TSC_F_BW_LSB +: 6];
    next_fref = rf[TSC_I_FREF][TSC_F_FREF_LSB +: 5];
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      lock_o <= 1'b0;
      stat <= 8'h80;
      analog_pd_o <= 1'b0;
      bypass_en_o <= 1'b1;
      port_out_o <= 2'h0;
      port_out_oe_n_o <= 2'h3;
      pll_div_o <= 15'h0000;
      ref_div_sel_o <= 5'h00;
      osc_band_o <= 2'h0;
      filter_bw_code_o <= TSC_RST[TSC_I_BW][TSC_F_BW_LSB +: 6];
      filter_ref_div_o <= TSC_RST[TSC_I_FREF][TSC_F_FREF_LSB +: 5];
    end else if (ce_i) begin
      lock_o <= next_lock;
      stat <= next_stat;
      analog_pd_o <= next_pd;
      bypass_en_o <= next_byp;
      port_out_o <= 2'h0;
      port_out_oe_n_o <= next_port;
      pll_div_o <= next_div;
      ref_div_sel_o <= next_ref;
      osc_band_o <= next_band;
      filter_bw_code_o <= next_bw;
      filter_ref_div_o <= next_fref;
    end
  end

  // serial engine: samples sda on rising scl
  always_comb begin
    rx_byte = {sh[6:0], sda_i};
    next_mode = mode;
    next_sh = sh;
    next_tx = tx;
    next_ack = ack_pend;
    next_first = first;
    next_rd = rd_act;
    next_widx = wr_idx;
    next_wbyte = wr_byte;
    next_wtgl = wr_tgl;
    next_cnt = (cnt == TSC_BIT_ACK) ? 4'h0 : cnt + 4'h1;
    if (cnt != TSC_BIT_ACK) begin
      next_sh = rx_byte;
      next_tx = {tx[6:0], 1'b0};
    end
    if (cnt == TSC_BIT_LAST) begin
      case (mode)
        M_ADDR: begin
          if (rx_byte[7:1] == {TSC_ADDR_HI, st_s[3:2]}) begin
            next_ack = 1'b1;
            next_mode = rx_byte[0] ? M_READ : M_WRITE;
            next_rd = rx_byte[0];
          end else begin
            next_mode = M_IGNORE;
          end
        end
        M_WRITE: begin
          next_ack = 1'b1;
          next_first = 1'b0;
          // index saturates one past the last byte
          if (first) begin
            next_widx = tsc_first_byte(rx_byte);
          end else if (wr_idx <= TSC_LAST_BYTE) begin
            next_widx = wr_idx + 4'h1;
          end
          if (first || wr_idx < TSC_LAST_BYTE) begin
            next_wbyte = rx_byte;
            next_wtgl = ~wr_tgl;
          end
        end
        default: begin
        end
      endcase
    end
    if (cnt == TSC_BIT_ACK) begin
      next_ack = 1'b0;
      if (mode == M_READ) begin
        if (!ack_pend && sda_i) begin
          next_mode = M_IGNORE;
        end else begin
          // master ack or own address ack: send status again
          next_tx = {st_s[1:0], 6'h00};
        end
      end
    end
  end

  // frame state, cleared by every start and stop
  always_ff @(posedge scl_i or posedge bus_rst) begin
    if (bus_rst) begin
      mode <= M_ADDR;
      cnt <= 4'h0;
      sh <= 8'h00;
      tx <= 8'hFF;
      ack_pend <= 1'b0;
      first <= 1'b1;
      rd_act <= 1'b0;
    end else begin
      mode <= next_mode;
      cnt <= next_cnt;
      sh <= next_sh;
      tx <= next_tx;
      ack_pend <= next_ack;
      first <= next_first;
      rd_act <= next_rd;
    end
  end

  // handshake words live across frames; toggles must not reset mid-run
  always_ff @(posedge scl_i or posedge rst_i) begin
    if (rst_i) begin
      wr_idx <= TSC_FIRST_BYTE;
      wr_byte <= 8'h00;
      wr_tgl <= 1'b0;
      st_m <= 4'h0;
      st_s <= 4'h0;
    end else begin
      wr_idx <= next_widx;
      wr_byte <= next_wbyte;
      wr_tgl <= next_wtgl;
      st_m <= {id_bits, stat[TSC_S_POR], stat[TSC_S_LOCK]};
      st_s <= st_m;
    end
  end

  // data drive changes on falling scl, while scl is low
  always_comb begin
    next_oe_n = 1'b1;
    if (cnt == TSC_BIT_ACK) begin
      next_oe_n = ~ack_pend;
    end else if (mode == M_READ) begin
      next_oe_n = tx[7];
    end
  end

  always_ff @(negedge scl_i or posedge bus_rst) begin
    if (bus_rst) begin
      sda_oe_n_o <= 1'b1;
      sda_o <= 1'b0;
    end else begin
      sda_oe_n_o <= next_oe_n;
      sda_o <= 1'b0;
    end
  end

  // serial side checks
  AST_ADDR_ACK: assert property (@(posedge scl_i) disable iff (bus_rst)
    mode == M_ADDR && cnt == TSC_BIT_LAST && rx_byte[7:1] == {TSC_ADDR_HI, st_s[3:2]}
    |=> ack_pend && mode == ($past(sda_i) ? M_READ : M_WRITE))
    else $error("matching address not acknowledged in right mode");

  AST_NO_MATCH: assert property (@(posedge scl_i) disable iff (bus_rst)
    mode == M_ADDR && cnt == TSC_BIT_LAST && rx_byte[7:1] != {TSC_ADDR_HI, st_s[3:2]}
    |=> mode == M_IGNORE && !ack_pend && sda_oe_n_o)
    else $error("foreign address touched the bus");

  AST_WR_ACK: assert property (@(posedge scl_i) disable iff (bus_rst)
    mode == M_WRITE && cnt == TSC_BIT_LAST |=> ack_pend && !sda_oe_n_o)
    else $error("written byte not acknowledged");

  AST_NACK_STOP: assert property (@(posedge scl_i) disable iff (bus_rst)
    mode == M_READ && cnt == TSC_BIT_ACK && !ack_pend && sda_i
    |=> mode == M_IGNORE ##1 sda_oe_n_o [*2])
    else $error("transmission went on after master nack");

  AST_WR_RANGE: assert property (@(posedge scl_i) disable iff (bus_rst)
    $changed(wr_tgl) |-> wr_idx >= TSC_FIRST_BYTE && wr_idx <= TSC_LAST_BYTE)
    else $error("write outside bytes two to twelve");

  // clk side checks
  AST_PD_SLEEP: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && (slp_s || pd_bit) |=> analog_pd_o)
    else $error("power down missed");

  AST_PD_RUN: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && !slp_s && !pd_bit |=> !analog_pd_o)
    else $error("powered down with both sources clear");

  AST_BYPASS: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i |=> bypass_en_o == !$past(byp_off))
    else $error("bypass enable does not follow its bit");

  AST_PORT: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i |=> port_out_oe_n_o == ~$past(port_bits) && port_out_o == 2'h0)
    else $error("general output drive wrong");

  AST_LOCK: assert property (@(posedge clk_i) disable iff (rst_i)
    lock_o == stat[TSC_S_LOCK])
    else $error("lock pin and status bit differ");

  AST_POR_CLR: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && stop_ev && rd_s |=> !por)
    else $error("power-on flag not cleared by stop after read");

  AST_REF: assert property (@(posedge clk_i) disable iff (rst_i)
    ref_div_sel_o <= TSC_REF_MAX)
    else $error("reference ratio code out of range");

  // main scenarios
  COV_READ_MORE: cover property (@(posedge scl_i) disable iff (bus_rst)
    mode == M_READ && cnt == TSC_BIT_ACK && !ack_pend && !sda_i);
  COV_WRITE_PAST: cover property (@(posedge scl_i) disable iff (bus_rst)
    mode == M_WRITE && cnt == TSC_BIT_LAST && !first && wr_idx >= TSC_LAST_BYTE);
  COV_IGNORE: cover property (@(posedge scl_i) disable iff (bus_rst)
    mode == M_ADDR ##1 mode == M_IGNORE);
  COV_POR_CLR: cover property (@(posedge clk_i) disable iff (rst_i)
    ce_i && stop_ev && rd_s);

endmodule

// ---- testbench/tsc_i2c_master_model.sv ----
// tsc_i2c_master_model: serial bus master that drives scl and pulls sda
// assumes: sda is resolved with a pull-up in the bench, scl 80 ns period
`timescale 1ns/100ps

module tsc_i2c_master_model (
  // bus pins
  output logic scl,
  output logic sda_pull,
  input wire logic sda
);
  localparam time Q = 20; // quarter of the bus period

  // scl stands high and sda released outside frames
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end

  // start: sda falls while scl high; odd offset keeps scl off the clk grid
  task automatic start();
    #3.3;
    sda_pull = 1'b1;
    #(2 * Q);
    scl = 1'b0;
  endtask

  // one bit: data changed mid-low, sampled mid-high
  task automatic bit_io(input logic b, output logic s);
    #Q;
    sda_pull = !b;
    #Q;
    scl = 1'b1;
    #Q;
    s = sda;
    #Q;
    scl = 1'b0;
  endtask

  // byte out msb first, then release sda for the slave ack
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], s);
    end
    bit_io(1'b1, s);
    ack = !s;
  endtask

  // byte in; ack low only when another status byte is wanted
  task automatic recv_byte(input logic more, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, b[i]);
    end
    bit_io(!more, s);
  endtask

  // stop: sda rises while scl high, then an idle gap well over 6 clk
  task automatic stop();
    #Q;
    sda_pull = 1'b1;
    #Q;
    scl = 1'b1;
    #Q;
    sda_pull = 1'b0;
    #(5 * Q);
  endtask
endmodule

// ---- testbench/tsc_top_tb.sv ----
// tsc_top_tb: self-checking bench for the tuner serial control logic
// assumes: tsc_pkg, tsc_top and the master model are compiled first
`timescale 1ns/100ps

module tsc_top_tb;
  import tsc_pkg::*;
  // clock, reset and pins
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic ce_i = 1'b1;
  logic [2:0] strap_lvl_i = 3'h0;
  logic sleep_i = 1'b0;
  logic pll_lock_i = 1'b0;
  logic scl, m_pull, sda_w, sda_o, sda_oe_n_o;
  logic lock_o, analog_pd_o, bypass_en_o;
  logic [1:0] port_out_o, port_out_oe_n_o, port_w, osc_band_o;
  logic [14:0] pll_div_o, d;
  logic [4:0] ref_div_sel_o, filter_ref_div_o;
  logic [5:0] filter_bw_code_o;
  logic [2:0] k;
  logic [7:0] s0, s1, s2, dev;
  logic [2:0] th [4] = '{3'h0, 3'h1, 3'h3, 3'h7};
  logic [14:0] dv [3] = '{15'h0010, 15'h0900, 15'h1234};
  int bad_count = 0;
  int n_checks = 0;

  // pull-ups on sda and on the open-collector outputs
  assign sda_w = m_pull ? 1'b0 : (sda_oe_n_o ? 1'b1 : sda_o);
  assign port_w = port_out_oe_n_o | port_out_o;

  always #5 clk_i = ~clk_i;

  tsc_top tsc_top_inst (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .scl_i(scl),
    .sda_i(sda_w), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o), .strap_lvl_i(strap_lvl_i),
    .sleep_i(sleep_i), .pll_lock_i(pll_lock_i), .lock_o(lock_o),
    .analog_pd_o(analog_pd_o), .bypass_en_o(bypass_en_o), .port_out_o(port_out_o),
    .port_out_oe_n_o(port_out_oe_n_o), .pll_div_o(pll_div_o),
    .ref_div_sel_o(ref_div_sel_o), .osc_band_o(osc_band_o),
    .filter_bw_code_o(filter_bw_code_o), .filter_ref_div_o(filter_ref_div_o));

  tsc_i2c_master_model tsc_i2c_master_model_inst (.scl(scl), .sda_pull(m_pull),
    .sda(sda_w));

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // reset held 8 cycles, then the idle gap before any start
  task automatic do_reset();
    @(negedge clk_i);
    rst_i = 1'b1;
    repeat (8) @(negedge clk_i);
    rst_i = 1'b0;
    repeat (6) @(negedge clk_i);
  endtask

  // write frame: address and up to two bytes, acks returned
  task automatic frame(input logic [7:0] a, input logic [7:0] b0, input logic [7:0] b1,
    input int n, output logic [2:0] ack);
    ack = 3'h0;
    tsc_i2c_master_model_inst.start();
    tsc_i2c_master_model_inst.send_byte(a, ack[0]);
    if (n > 0) tsc_i2c_master_model_inst.send_byte(b0, ack[1]);
    if (n > 1) tsc_i2c_master_model_inst.send_byte(b1, ack[2]);
    tsc_i2c_master_model_inst.stop();
    repeat (2) @(negedge clk_i);
  endtask

  // status read: first byte acked, second refused, third after release
  task automatic rd(output logic [7:0] a0, output logic [7:0] a1, output logic [7:0] a2);
    logic ack;
    tsc_i2c_master_model_inst.start();
    tsc_i2c_master_model_inst.send_byte(dev | 8'h01, ack);
    chk("read ack", ack, 1'b1);
    tsc_i2c_master_model_inst.recv_byte(1'b1, a0);
    tsc_i2c_master_model_inst.recv_byte(1'b0, a1);
    tsc_i2c_master_model_inst.recv_byte(1'b0, a2);
    tsc_i2c_master_model_inst.stop();
    repeat (2) @(negedge clk_i);
  endtask

  initial begin
    // each strap level answers only its own write address
    for (int s = 0; s < 4; s++) begin
      strap_lvl_i = th[s];
      do_reset();
      chk("bypass", bypass_en_o, 1'b1);
      chk("ports", port_w, 2'h3);
      chk("port oe", port_out_oe_n_o, 2'h3);
      for (int a = 0; a < 4; a++) begin
        frame(8'hC0 + 8'(2 * a), 8'h00, 8'h00, 0, k);
        chk("addr ack", k[0], a == s);
      end
    end
    dev = 8'hC6;
    // divider values on each side of the band limits
    for (int i = 0; i < 3; i++) begin
      d = dv[i];
      frame(dev, {1'b0, d[14:8]}, d[7:0], 2, k);
      chk("acks", k, 3'h7);
      chk("divider", pll_div_o, d);
      chk("band", osc_band_o, (d < TSC_BAND_LO) ? 2'h0 : (d < TSC_BAND_HI) ? 2'h1 : 2'h2);
    end
    // ratio code above the top clamps; port 0 pulls low
    frame(dev, 8'h80, 8'h9F, 2, k);
    chk("ratio", ref_div_sel_o, TSC_REF_MAX);
    chk("ports", port_w, 2'h2);
    frame(dev, 8'h80, 8'h05, 2, k);
    chk("ratio", ref_div_sel_o, 5'h05);
    // power-down and bypass-off bits, bandwidth code 3E, port 1 on
    frame(dev, 8'hC9, 8'hFC, 2, k);
    chk("pd", analog_pd_o, 1'b1);
    chk("bypass", bypass_en_o, 1'b0);
    chk("bw", filter_bw_code_o, 6'h3E);
    chk("ports", port_w, 2'h1);
    // filter reference divider at code 1B
    frame(dev, 8'hDB, 8'h6C, 2, k);
    chk("fref", filter_ref_div_o, 5'h1B);
    // byte after the twelfth is acked but stored nowhere
    frame(dev, 8'hF0, 8'hAA, 2, k);
    chk("acks", k, 3'h7);
    chk("divider", pll_div_o, 15'h1234);
    chk("bw", filter_bw_code_o, 6'h3E);
    // foreign address with data behind it
    frame(8'hC0, 8'h00, 8'h00, 2, k);
    chk("acks", k, 3'h0);
    chk("divider", pll_div_o, 15'h1234);
    // sleep pin alone, bypass on and untouched by it
    frame(dev, 8'hC0, 8'h7C, 2, k);
    for (int p = 0; p < 2; p++) begin
      @(negedge clk_i);
      sleep_i = p[0];
      repeat (5) @(negedge clk_i);
      chk("pd", analog_pd_o, p[0]);
      chk("bypass", bypass_en_o, 1'b1);
    end
    // clock enable low freezes the outputs, high lets them catch up
    @(negedge clk_i);
    ce_i = 1'b0;
    sleep_i = 1'b0;
    repeat (5) @(negedge clk_i);
    chk("pd frozen", analog_pd_o, 1'b1);
    ce_i = 1'b1;
    repeat (5) @(negedge clk_i);
    chk("pd", analog_pd_o, 1'b0);
    // lock pin and status, then the power-on flag gone after the stop
    sleep_i = 1'b0;
    pll_lock_i = 1'b1;
    repeat (5) @(negedge clk_i);
    chk("lock pin", lock_o, 1'b1);
    rd(s0, s1, s2);
    chk("status", s0, 8'hC0);
    chk("status again", s1, 8'hC0);
    chk("released", s2, 8'hFF);
    pll_lock_i = 1'b0;
    repeat (5) @(negedge clk_i);
    chk("lock pin", lock_o, 1'b0);
    rd(s0, s1, s2);
    chk("status", s0, 8'h00);
    close_out();
  end

  // watchdog well beyond the roughly 46 us the tests take
  initial begin
    #500000;
    bad_count++;
    close_out();
  end
endmodule
